//--- hdl/xbc_defines.vh
// Purpose: Register offsets, field positions and reset values of the external bus controller.
// Assumes: APB byte addresses, one 32-bit word per register, config data in the low 16 bits.
// Notes: Included by the controller design file only.
`ifndef XBC_DEFINES_VH
`define XBC_DEFINES_VH

`define XBC_SYSTEM_CONFIG_REGISTER_OFF 8'h00
`define XBC_PSW_OFF 8'h04
`define XBC_DBC_OFF 8'h08
`define XBC_ASEL_BASE 8'h10
`define XBC_WBC_BASE 8'h20
`define XBC_XADDR_OFF 8'h30
`define XBC_XWDATA_OFF 8'h34
`define XBC_XCMD_OFF 8'h38
`define XBC_XSTAT_OFF 8'h3C
`define XBC_XRDATA_OFF 8'h40

`define XBC_SC_CHIP_SELECT_TIMING_CFG 0
`define XBC_SC_SPC_LSB 1
`define XBC_SC_EXTEN 3
`define XBC_SC_RESET 16'h0006

`define XBC_PSW_ARBEN 0
`define XBC_PSW_HLDADIR 1
`define XBC_PSW_RESET 2'h0

`define XBC_BC_MCYC_LSB 0
`define XBC_BC_TRI 4
`define XBC_BC_RWDLY 5
`define XBC_BC_MUX 6
`define XBC_BC_W16 7
`define XBC_BC_ALECTL 8
`define XBC_BC_ACT 9
`define XBC_BC_RDYEN 12
`define XBC_BC_READY_POLARITY 13
`define XBC_DBC_RESET 16'h039F
`define XBC_WBC_RESET 16'h0000
`define XBC_ASEL_RESET 16'h0000

`define XBC_SPC_64K 2'h0
`define XBC_SPC_256K 2'h1
`define XBC_SPC_1M 2'h2
`define XBC_SPC_16M 2'h3

`define XBC_CMD_GO 0
`define XBC_CMD_WR 1
`define XBC_ST_BUSY 0
`define XBC_ST_ERR 1
`define XBC_ST_HOLD 2
`define XBC_ST_WIN_LSB 4

`endif

//--- hdl/xbc_ext_bus_ctrl.v
// Purpose: External bus controller with APB registers, windows, chip selects and arbitration.
// Assumes: mclk 125 MHz; pins pass two flops; external read data stable two cycles before end.
// Notes: Software launches one external access at a time through the command register.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "xbc_defines.vh"
module xbc_ext_bus_ctrl (
  input wire mclk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [15:0] ad_in,
  output reg [15:0] ad_out,
  output reg ad_oe_lo,
  output reg ad_oe_hi,
  output reg [15:0] addr_out,
  output reg addr_oe,
  output reg [7:0] seg_addr_out,
  output reg [7:0] seg_oe,
  output reg ale,
  output reg rd_n,
  output reg wr_n,
  output reg strobe_oe,
  output wire [4:0] chip_select_n,
  output reg cs_oe,
  input wire ready_in,
  input wire hold_n_in,
  input wire hold_acknowledge_in,
  output reg hold_acknowledge_out,
  output reg hold_acknowledge_oe,
  output reg bus_request_out_n,
  output reg bus_request_out_oe
);
  localparam S_IDLE = 7'h01;
  localparam S_ALE = 7'h02;
  localparam S_DLY = 7'h04;
  localparam S_STRB = 7'h08;
  localparam S_TRI = 7'h10;
  localparam S_HOLD = 7'h20;
  localparam S_REQ = 7'h40;

  reg [15:0] system_config_register_q;
  reg [1:0] psw_q;
  reg [15:0] dbc_q;
  reg [15:0] asel_q [1:4];
  reg [15:0] wbc_q [1:4];
  reg [23:0] xaddr_q;
  reg [15:0] xwdata_q;
  reg [15:0] rdata_q;
  reg pend_q;
  reg cmd_wr_q;
  reg err_q;
  reg [6:0] state_q;
  reg [3:0] cnt_q;
  reg [15:0] cfg_q;
  reg [2:0] idx_q;
  reg [4:0] cs_pos_q;
  reg [4:0] cs_half_q;
  reg [31:0] rd_mux;
  reg addr_hit;
  reg [2:0] sel_idx;
  reg [15:0] sel_cfg;
  reg err_set;
  wire [15:0] din_s;
  wire ready_s;
  wire hold_n_s;
  wire hold_acknowledge_s;
  integer i;
  integer j;

  wire [1:0] spc = system_config_register_q[`XBC_SC_SPC_LSB+1:`XBC_SC_SPC_LSB];
  wire arb_en = psw_q[`XBC_PSW_ARBEN];
  wire slave = psw_q[`XBC_PSW_HLDADIR];
  wire ext_en = system_config_register_q[`XBC_SC_EXTEN];
  wire wr_en = psel & penable & pwrite & pready;
  // Hold is not busy: a command given while the bus is lent out waits for its return.
  wire busy = pend_q | ~(state_q[0] | state_q[5]);
  wire cmd_go = wr_en & (paddr == `XBC_XCMD_OFF) & pwdata[`XBC_CMD_GO];
  wire err_clr = wr_en & (paddr == `XBC_XSTAT_OFF) & pwdata[`XBC_ST_ERR];

  function [23:0] space_mask;
    input [1:0] code;
    begin
      case (code)
        `XBC_SPC_64K: space_mask = 24'h00FFFF;
        `XBC_SPC_256K: space_mask = 24'h03FFFF;
        `XBC_SPC_1M: space_mask = 24'h0FFFFF;
        default: space_mask = 24'hFFFFFF;
      endcase
    end
  endfunction

  function [7:0] seg_lines;
    input [1:0] code;
    begin
      case (code)
        `XBC_SPC_64K: seg_lines = 8'h00;
        `XBC_SPC_256K: seg_lines = 8'h03;
        `XBC_SPC_1M: seg_lines = 8'h0F;
        default: seg_lines = 8'hFF;
      endcase
    end
  endfunction

  // The size code doubles a 4 Kbyte window per step; low bits below the size are don't-care.
  function win_hit;
    input [23:0] a;
    input [15:0] sel;
    reg [11:0] m;
    begin
      m = 12'hFFF << sel[3:0];
      win_hit = (((a[23:12] ^ sel[15:4]) & m) == 12'h000);
    end
  endfunction

  wire [23:0] eff_addr = xaddr_q & space_mask(spc);

  xbc_sync #(
    .W(19)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d({ready_in, hold_n_in, hold_acknowledge_in, ad_in}),
    .q({ready_s, hold_n_s, hold_acknowledge_s, din_s})
  );

  // Later windows in the loop overwrite earlier ones, so window four wins over all.
  always @*
  begin
    sel_idx = 3'h0;
    sel_cfg = dbc_q;
    for (i = 1; i < 5; i = i + 1)
    begin
      if (wbc_q[i][`XBC_BC_ACT] && win_hit(eff_addr, asel_q[i]))
      begin
        sel_idx = i[2:0];
        sel_cfg = wbc_q[i];
      end
    end
  end

  always @*
  begin
    rd_mux = 32'h00000000;
    addr_hit = 1'b1;
    case (paddr)
      `XBC_SYSTEM_CONFIG_REGISTER_OFF: rd_mux = {16'h0000, system_config_register_q};
      `XBC_PSW_OFF: rd_mux = {30'h00000000, psw_q};
      `XBC_DBC_OFF: rd_mux = {16'h0000, dbc_q};
      8'h10: rd_mux = {16'h0000, asel_q[1]};
      8'h14: rd_mux = {16'h0000, asel_q[2]};
      8'h18: rd_mux = {16'h0000, asel_q[3]};
      8'h1C: rd_mux = {16'h0000, asel_q[4]};
      8'h20: rd_mux = {16'h0000, wbc_q[1]};
      8'h24: rd_mux = {16'h0000, wbc_q[2]};
      8'h28: rd_mux = {16'h0000, wbc_q[3]};
      8'h2C: rd_mux = {16'h0000, wbc_q[4]};
      `XBC_XADDR_OFF: rd_mux = {8'h00, xaddr_q};
      `XBC_XWDATA_OFF: rd_mux = {16'h0000, xwdata_q};
      `XBC_XCMD_OFF: rd_mux = {30'h00000000, cmd_wr_q, pend_q};
      `XBC_XSTAT_OFF: rd_mux = {25'h0000000, idx_q, 1'b0, state_q[5], err_q, busy};
      `XBC_XRDATA_OFF: rd_mux = {16'h0000, rdata_q};
      default: addr_hit = 1'b0;
    endcase
  end

  // Default timing moves the chip selects on the falling edge in the middle of the cycle.
  always @(negedge mclk or negedge resetn)
  begin
    if (!resetn)
      cs_half_q <= 5'h1F;
    else
      cs_half_q <= cs_pos_q;
  end

  // A mux of two flops: the half-cycle variant cannot come from a rising-edge register alone.
  assign chip_select_n = system_config_register_q[`XBC_SC_CHIP_SELECT_TIMING_CFG] ? cs_pos_q : cs_half_q;

  task own_bus;
    input v;
    begin
      addr_oe <= v;
      strobe_oe <= v;
      cs_oe <= v;
      seg_oe <= v ? seg_lines(spc) : 8'h00;
    end
  endtask

  task start_cycle;
    begin
      cfg_q <= sel_cfg;
      idx_q <= sel_idx;
      addr_out <= eff_addr[15:0];
      seg_addr_out <= eff_addr[23:16];
      ale <= 1'b1;
      cs_pos_q <= ~(5'h01 << sel_idx);
      ad_out <= eff_addr[15:0];
      ad_oe_lo <= sel_cfg[`XBC_BC_MUX];
      ad_oe_hi <= sel_cfg[`XBC_BC_MUX];
      cnt_q <= {3'h0, sel_cfg[`XBC_BC_ALECTL]};
      own_bus(1'b1);
      state_q <= S_ALE;
    end
  endtask

  task start_strobe;
    begin
      rd_n <= cmd_wr_q;
      wr_n <= ~cmd_wr_q;
      ad_out <= xwdata_q;
      ad_oe_lo <= cmd_wr_q;
      ad_oe_hi <= cmd_wr_q & cfg_q[`XBC_BC_W16];
      cnt_q <= cfg_q[`XBC_BC_MCYC_LSB+3:`XBC_BC_MCYC_LSB];
      state_q <= S_STRB;
    end
  endtask

  task finish;
    begin
      state_q <= S_IDLE;
      if (arb_en & slave)
      begin
        bus_request_out_n <= 1'b1;
        own_bus(1'b0);
      end
    end
  endtask

  always @*
  begin
    err_set = 1'b0;
    if (state_q[0] && pend_q && !(arb_en && !slave && !hold_n_s))
      err_set = !ext_en || !sel_cfg[`XBC_BC_ACT];
  end

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
      system_config_register_q <= `XBC_SC_RESET;
      psw_q <= `XBC_PSW_RESET;
      dbc_q <= `XBC_DBC_RESET;
      for (j = 1; j < 5; j = j + 1)
      begin
        asel_q[j] <= `XBC_ASEL_RESET;
        wbc_q[j] <= `XBC_WBC_RESET;
      end
      xaddr_q <= 24'h000000;
      xwdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      pend_q <= 1'b0;
      cmd_wr_q <= 1'b0;
      err_q <= 1'b0;
      state_q <= S_IDLE;
      cnt_q <= 4'h0;
      cfg_q <= 16'h0000;
      idx_q <= 3'h0;
      cs_pos_q <= 5'h1F;
      ad_out <= 16'h0000;
      ad_oe_lo <= 1'b0;
      ad_oe_hi <= 1'b0;
      addr_out <= 16'h0000;
      addr_oe <= 1'b1;
      seg_addr_out <= 8'h00;
      seg_oe <= 8'hFF;
      ale <= 1'b0;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      strobe_oe <= 1'b1;
      cs_oe <= 1'b1;
      hold_acknowledge_out <= 1'b1;
      hold_acknowledge_oe <= 1'b0;
      bus_request_out_n <= 1'b1;
      bus_request_out_oe <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable)
      begin
        prdata <= rd_mux;
        pslverr <= ~addr_hit;
      end
      if (wr_en)
      begin
        case (paddr)
          `XBC_SYSTEM_CONFIG_REGISTER_OFF: system_config_register_q <= {12'h000, pwdata[3:0]};
          `XBC_PSW_OFF: psw_q <= pwdata[1:0];
          `XBC_DBC_OFF: dbc_q <= pwdata[15:0];
          8'h10: asel_q[1] <= pwdata[15:0];
          8'h14: asel_q[2] <= pwdata[15:0];
          8'h18: asel_q[3] <= pwdata[15:0];
          8'h1C: asel_q[4] <= pwdata[15:0];
          8'h20: wbc_q[1] <= pwdata[15:0];
          8'h24: wbc_q[2] <= pwdata[15:0];
          8'h28: wbc_q[3] <= pwdata[15:0];
          8'h2C: wbc_q[4] <= pwdata[15:0];
          `XBC_XADDR_OFF: xaddr_q <= pwdata[23:0];
          `XBC_XWDATA_OFF: xwdata_q <= pwdata[15:0];
          default: ;
        endcase
      end
      // A new command while one is in flight is dropped rather than queued.
      if (cmd_go && !busy)
      begin
        pend_q <= 1'b1;
        cmd_wr_q <= pwdata[`XBC_CMD_WR];
      end
      err_q <= err_set | (err_q & ~err_clr);
      // Arbitration pins stay passive until arbitration is enabled.
      hold_acknowledge_oe <= arb_en & ~slave;
      bus_request_out_oe <= arb_en;
      case (state_q)
        S_IDLE:
        begin
          if (arb_en && !slave && !hold_n_s)
          begin
            own_bus(1'b0);
            ad_oe_lo <= 1'b0;
            ad_oe_hi <= 1'b0;
            hold_acknowledge_out <= 1'b0;
            state_q <= S_HOLD;
          end
          else if (pend_q)
          begin
            if (err_set)
              pend_q <= 1'b0;
            else if (arb_en && slave)
            begin
              bus_request_out_n <= 1'b0;
              state_q <= S_REQ;
            end
            else
              start_cycle;
          end
          else
            own_bus(~(arb_en & slave));
        end
        S_HOLD:
        begin
          bus_request_out_n <= ~pend_q;
          if (hold_n_s)
          begin
            hold_acknowledge_out <= 1'b1;
            bus_request_out_n <= 1'b1;
            state_q <= S_IDLE;
          end
        end
        S_REQ:
        begin
          if (!hold_acknowledge_s)
            start_cycle;
        end
        S_ALE:
        begin
          if (cnt_q == 4'h0)
          begin
            ale <= 1'b0;
            ad_oe_lo <= 1'b0;
            ad_oe_hi <= 1'b0;
            if (cfg_q[`XBC_BC_RWDLY])
              state_q <= S_DLY;
            else
              start_strobe;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        S_DLY:
          start_strobe;
        S_STRB:
        begin
          if (cnt_q != 4'h0)
            cnt_q <= cnt_q - 4'h1;
          else if (!cfg_q[`XBC_BC_RDYEN] || (ready_s == cfg_q[`XBC_BC_READY_POLARITY]))
          begin
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            ad_oe_lo <= 1'b0;
            ad_oe_hi <= 1'b0;
            cs_pos_q <= 5'h1F;
            pend_q <= 1'b0;
            if (!cmd_wr_q)
              rdata_q <= cfg_q[`XBC_BC_W16] ? din_s : {8'h00, din_s[7:0]};
            if (cfg_q[`XBC_BC_TRI])
              state_q <= S_TRI;
            else
              finish;
          end
        end
        S_TRI:
          finish;
        default:
          state_q <= S_IDLE;
      endcase
    end
  end
endmodule

//--- hdl/xbc_sync.v
// Purpose: Two-flop synchroniser for pin inputs.
// Assumes: Inputs are asynchronous to mclk.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module xbc_sync #(
  parameter W = 1
) (
  input wire mclk,
  input wire resetn,
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_q;

  always @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_q <= {W{1'b0}};
      q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

//--- sim/xbc_ext_bus_ctrl_chk.sv
// Purpose: Port checks of the external bus controller.
// Assumes: Sees only the top module ports.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
module xbc_ext_bus_ctrl_chk (
  input wire mclk,
  input wire resetn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  input wire ad_oe_lo,
  input wire ad_oe_hi,
  input wire addr_oe,
  input wire strobe_oe,
  input wire cs_oe,
  input wire [7:0] seg_oe,
  input wire [4:0] chip_select_n,
  input wire hold_acknowledge_out,
  input wire hold_acknowledge_oe,
  input wire bus_request_out_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("pready late");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready long");
  property p_ale_len; $rose(ale) |-> ##[1:2] !ale; endproperty
  a_ale_len: assert property (p_ale_len) else $error("ale length");
  property p_addr_first; ale |-> rd_n && wr_n; endproperty
  a_addr_first: assert property (p_addr_first) else $error("strobe in ale");
  property p_rdwr; !rd_n |-> wr_n; endproperty
  a_rdwr: assert property (p_rdwr) else $error("rd and wr low");
  property p_cs; $onehot0(~chip_select_n); endproperty
  a_cs: assert property (p_cs) else $error("two selects");
  property p_byte; ad_oe_hi |-> ad_oe_lo; endproperty
  a_byte: assert property (p_byte) else $error("high byte alone");
  property p_wdata; !wr_n |-> ad_oe_lo; endproperty
  a_wdata: assert property (p_wdata) else $error("write undriven");
  property p_seg; seg_oe inside {8'hFF, 8'h0F, 8'h03, 8'h00}; endproperty
  a_seg: assert property (p_seg) else $error("segment enables");
  property p_float;
    hold_acknowledge_oe && !hold_acknowledge_out && !$past(hold_acknowledge_out) |-> !(addr_oe || strobe_oe || cs_oe || ad_oe_lo);
  endproperty
  a_float: assert property (p_float) else $error("drives while held");
  property p_arb; hold_acknowledge_oe |-> bus_request_out_oe; endproperty
  a_arb: assert property (p_arb) else $error("ack without arb");
endmodule

//--- sim/xbc_ext_bus_ctrl_tb_top.sv
// Purpose: Self-checking bench for the external bus controller.
// Assumes: One external access at a time, launched and polled over APB.
// Notes: Read results are compared by a monitor from a queue of notes.
`timescale 1ns/1ps
module xbc_ext_bus_ctrl_tb_top;
  logic mclk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, d;
  logic pready, pslverr, ale, rd_n, wr_n, ready_in, hold_n_in = 1, hold_acknowledge_in = 1;
  logic [15:0] ad_in, ad_out, addr_out;
  logic [4:0] chip_select_n;
  logic [7:0] seg_oe, seg_addr_out;
  logic mux = 0, pol = 0, hold_acknowledge_out, hold_acknowledge_oe, addr_oe, bus_request_out_n;
  logic [3:0] dly = 4'h0;
  logic [32:0] q[$], m[$], e, k;
  logic [4:0] csq[$];
  logic [7:0] sgq[$];
  logic cs_cfg = 0, ale_q = 0;
  logic [7:0] sg [4] = '{8'h00, 8'h03, 8'h0F, 8'hFF};
  logic [15:0] asl [4] = '{16'h0042, 16'h0050, 16'h0800, 16'h0800};
  logic [15:0] wbc [4] = '{16'h0285, 16'h02C5, 16'h0285, 16'h3205};
  logic [23:0] ta [4] = '{24'h004100, 24'h005010, 24'h080020, 24'h200000};
  logic [4:0] tc [4] = '{5'h1D, 5'h1B, 5'h0F, 5'h1E};
  logic [2:0] tw [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  int err_count = 0, check_count = 0;
  always #4 mclk = ~mclk;
  xbc_ext_bus_ctrl dut (.*, .ad_oe_lo(), .ad_oe_hi(), .strobe_oe(),
    .cs_oe(), .bus_request_out_oe());
  xbc_mem_model mem (.*);
  task automatic chk(string n, logic [32:0] x, logic [32:0] g);
    check_count++;
    if (g !== x)
    begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", n, x, g);
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] v, logic [32:0] x = 0,
    logic [32:0] mk = 0);
    @(posedge mclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    if (!w)
    begin
      q.push_back(x);
      m.push_back(mk);
    end
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (!pready);
    rd = prdata;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic ext(logic [23:0] a, logic w, logic [15:0] v, int i);
    apb(1, 8'h30, a);
    apb(1, 8'h34, v);
    csq.push_back(tc[i]);
    sgq.push_back(a[23:16]);
    apb(1, 8'h38, {w, 1'b1});
    do apb(0, 8'h3C, 0); while (rd[0]);
    apb(0, 8'h3C, 0, {tw[i], 4'h0}, 33'h73);
  endtask
  always @(posedge mclk)
  begin
    if (psel && penable && pready && !pwrite)
    begin
      e = q.pop_front();
      k = m.pop_front();
      if (k != 0)
        chk("prdata", e, {pslverr, prdata} & k);
    end
    if ($fell(rd_n && wr_n))
    begin
      chk("chip_select_n", csq.pop_front(), chip_select_n);
      chk("seg_addr_out", sgq.pop_front(), seg_addr_out);
    end
  end
  // Looked at just after the edge that raises ale: default timing still holds the selects back.
  always @(posedge mclk)
  begin
    ale_q <= ale;
    #2;
    if (ale && !ale_q)
      chk("cs_at_ale", cs_cfg ? csq[0] : 5'h1F, chip_select_n);
  end
  initial
  begin
    #500us;
    err_count++;
    stop_test;
  end
  initial
  begin
    void'($urandom(32'h6AF6));
    repeat (8) @(posedge mclk);
    resetn <= 1;
    apb(0, 8'h00, 0, 33'h6, '1);
    apb(0, 8'h04, 0, 0, '1);
    apb(0, 8'h08, 0, 33'h39F, '1);
    apb(0, 8'h10, 0, 0, '1);
    apb(0, 8'h50, 0, 33'h1_0000_0000, '1);
    apb(1, 8'h38, 1);
    apb(0, 8'h3C, 0, 2, 2);
    apb(1, 8'h3C, 2);
    for (int i = 0; i < 4; i++)
    begin
      apb(1, 8'h00, {i[1:0], 1'b0} | 8);
      repeat (2) @(posedge mclk);
      chk("seg_oe", sg[i], seg_oe);
      apb(1, 8'h10 + 8'(4 * i), asl[i]);
      apb(1, 8'h20 + 8'(4 * i), wbc[i]);
    end
    pol <= 1;
    dly <= 4'($urandom_range(5));
    for (int i = 0; i < 4; i++)
    begin
      if (i == 2)
      begin
        apb(1, 8'h00, 32'h0000000F);
        cs_cfg <= 1;
      end
      mux <= (i == 1);
      d = $urandom;
      ext(ta[i], 1, d[15:0], i);
      ext(ta[i], 0, 0, i);
      apb(0, 8'h40, 0, (i == 2) ? {25'h0, d[7:0]} : {17'h0, d[15:0]}, '1);
    end
    mux <= 0;
    apb(1, 8'h04, 1);
    hold_n_in <= 0;
    repeat (8) @(posedge mclk);
    chk("hold_acknowledge_oe", 1, hold_acknowledge_oe);
    chk("hold_acknowledge_out", 0, hold_acknowledge_out);
    chk("addr_oe", 0, addr_oe);
    fork
      ext(ta[3], 0, 0, 3);
      begin
        repeat (40) @(posedge mclk);
        chk("rd_n", 1, rd_n);
        hold_n_in <= 1;
      end
    join
    apb(1, 8'h04, 3);
    repeat (2) @(posedge mclk);
    chk("hold_acknowledge_oe", 0, hold_acknowledge_oe);
    fork
      ext(ta[3], 0, 0, 3);
      begin
        repeat (20) @(posedge mclk);
        chk("bus_request_out_n", 0, bus_request_out_n);
        hold_acknowledge_in <= 0;
      end
    join
    hold_acknowledge_in <= 1;
    stop_test;
  end
endmodule
bind xbc_ext_bus_ctrl xbc_ext_bus_ctrl_chk chk (.*);

//--- sim/xbc_mem_model.sv
// Purpose: External memory behind the bus controller, with a slow ready.
// Assumes: Address is taken while the latch strobe is high.
// Notes: Read lines show inverted history when not read, never a held value.
`timescale 1ns/1ps
module xbc_mem_model (
  input wire mclk,
  input wire mux,
  input wire pol,
  input wire [3:0] dly,
  input wire ale,
  input wire rd_n,
  input wire wr_n,
  input wire [15:0] addr_out,
  input wire [15:0] ad_out,
  output logic [15:0] ad_in = 16'h0000,
  output logic ready_in = 1'b0
);
  logic [15:0] mem [16];
  logic [3:0] a;
  int n;
  always @(posedge mclk)
  begin
    if (ale)
      a <= mux ? ad_out[3:0] : addr_out[3:0];
    if (!wr_n)
      mem[a] <= ad_out;
    n <= (rd_n && wr_n) ? 0 : n + 1;
    // Ready stays inactive outside cycles so a stale level cannot end one early.
    ready_in <= ((!rd_n || !wr_n) && n >= dly) ? pol : !pol;
    ad_in <= !rd_n ? mem[a] : ~ad_in;
  end
endmodule
